//--- ddr_ctrl_defs.svh
// Constants for the DDR SDRAM ECC controller: field positions, resets, counts
`ifndef DDR_CTRL_DEFS_SVH
`define DDR_CTRL_DEFS_SVH

// Base and boundary settings count 32-Mbyte units: address bits [31:25]
`define DDR_UNIT_LSB      25
`define DDR_UNIT_MSB      31
// Leaf select low bit for 128-Mbit x8; +1 per technology step, -1 for x16
`define DDR_LEAF_BASE     5'd25
// Row widths: 12 for 128-Mbit, 13 for 256/512-Mbit, 14 for 1-Gbit
`define DDR_ROW_BASE      4'd12
// Column widths: 10 for 128/256-Mbit x8, one more for 512-Mbit/1-Gbit, one less for x16
`define DDR_COL_BASE      4'd10
// Most 32-bit words one port may hold the memory for in a row
`define DDR_BURST_MAX     4'd8
// Byte enable values: none set (DDR_BE_FULL) and full word (DDR_BE_ALL)
`define DDR_BE_FULL       4'h0
`define DDR_BE_ALL        4'hf
// Reset values
`define DDR_CS_IDLE       2'h3
`define DDR_ZERO32        32'h0000_0000
`define DDR_ZERO8         8'h00

`endif

//--- ddr_ctrl_pkg.sv
// Types and ECC functions shared by the DDR SDRAM ECC controller
package ddr_ctrl_pkg;

	// Request from one internal port; held until its answer is seen
	typedef struct packed {
		logic        valid;
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} req_t;

	// Answer broadcast to all ports, tagged with the port number
	typedef struct packed {
		logic        valid;
		logic [1:0]  port;
		logic [31:0] rdata;
		logic        err;
	} resp_t;

	// Command word towards the memory devices
	typedef struct packed {
		logic [1:0]  cs_n;
		logic        leaf_select_high;
		logic        leaf_select_low;
		logic [13:0] row;
		logic [10:0] col;
		logic        rd;
		logic        wr;
	} mem_cmd_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RD   = 3'b001,
		S_WAIT = 3'b011,
		S_WR   = 3'b010,
		S_DONE = 3'b110
	} state_t;

	typedef enum logic [1:0] {
		TECH_128M = 2'h0,
		TECH_256M = 2'h1,
		TECH_512M = 2'h2,
		TECH_1G   = 2'h3
	} tech_t;

	typedef enum logic [1:0] {
		PORT_PROC = 2'h0,
		PORT_SYSA = 2'h1,
		PORT_SYSB = 2'h2,
		PORT_NONE = 2'h3
	} port_t;

	// Check code over a 64-bit word: 7 Hamming bits and an overall parity bit
	function automatic logic [7:0] ecc_gen(input logic [63:0] d);
		logic [7:0] c;
		logic [6:0] k;
		c = 8'h00;
		k = 7'h00;
		for (int p = 3; p < 72; p++) begin
			if ((p & (p - 1)) != 0) begin
				for (int b = 0; b < 7; b++) begin
					if (p[b]) c[b] = c[b] ^ d[k[5:0]];
				end
				k = k + 7'h01;
			end
		end
		c[7] = ^{d, c[6:0]};
		return c;
	endfunction

	// Flip the data bit that a syndrome points at; check-bit syndromes leave data alone
	function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [6:0] s);
		logic [31:0] f;
		logic [6:0]  k;
		f = d;
		k = 7'h00;
		for (int p = 3; p < 72; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (k < 7'd32 && s == p[6:0]) f[k[4:0]] = ~f[k[4:0]];
				k = k + 7'h01;
			end
		end
		return f;
	endfunction

endpackage

//--- ddr_sdram_ecc_controller.sv
// Three-port DDR SDRAM controller core with SEC-DED ECC and read-modify-write
`timescale 1ns/10ps
`default_nettype none
`include "ddr_ctrl_defs.svh"

module ddr_sdram_ecc_controller
	import ddr_ctrl_pkg::*;
(
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_n_i,
	input  wire req_t                       proc_req_i,
	input  wire req_t                       sysa_req_i,
	input  wire req_t                       sysb_req_i,
	output resp_t                           resp_o,
	input  wire logic [6:0]                 memory_base_setting_i,
	input  wire logic [6:0]                 bank0_boundary_setting_i,
	input  wire logic [6:0]                 bank1_boundary_setting_i,
	input  wire tech_t                      dev_tech_i,
	input  wire logic                       dev_x16_i,
	input  wire logic                       ecc_en_i,
	input  wire logic                       err_clr_i,
	output mem_cmd_t                        mem_cmd_o,
	output logic [31:0]                     mem_dq_o,
	output logic                            mem_dq_oe_o,
	input  wire logic [31:0]                mem_dq_i,
	output logic [7:0]                      memory_check_bits_o,
	output logic                            memory_check_bits_oe_o,
	input  wire logic [7:0]                 memory_check_bits_i,
	input  wire logic                       mem_rvalid_i,
	output logic                            sbe_flag_o,
	output logic                            mbe_flag_o,
	output logic [31:0]                     err_addr_o,
	output logic                            err_event_o
);

	// ************************************************************
	// Address decode
	// ************************************************************

	// Row, column and leaf of a bank offset
	function automatic mem_cmd_t map_addr(input logic [31:0] off, input tech_t t, input logic x16);
		mem_cmd_t   m;
		logic [3:0] colw;
		logic [3:0] roww;
		logic [4:0] lsb;
		logic [31:0] word;
		logic [31:0] rowv;
		m = '0;
		m.cs_n = `DDR_CS_IDLE;
		colw = `DDR_COL_BASE + {3'h0, t[1]} - {3'h0, x16};
		roww = `DDR_ROW_BASE + {3'h0, t != TECH_128M} + {3'h0, t == TECH_1G};
		lsb = `DDR_LEAF_BASE + {3'h0, t} - {4'h0, x16};
		word = off >> 2;
		rowv = word >> colw;
		m.col = 11'(word & ((32'h0000_0001 << colw) - 32'h0000_0001));
		m.row = 14'(rowv & ((32'h0000_0001 << roww) - 32'h0000_0001));
		m.leaf_select_low = off[lsb];
		m.leaf_select_high = off[lsb + 5'd1];
		return m;
	endfunction

	// ************************************************************
	// Pin input synchronisers
	// ************************************************************

	logic        rv_s1_ff;
	logic        rv_s2_ff;
	logic [31:0] dq_s1_ff;
	logic [31:0] dq_s2_ff;
	logic [7:0]  cb_s1_ff;
	logic [7:0]  cb_s2_ff;

	// Two stages on everything that comes from the memory pins
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rv_s1_ff <= 1'b0;
			rv_s2_ff <= 1'b0;
			dq_s1_ff <= `DDR_ZERO32;
			dq_s2_ff <= `DDR_ZERO32;
			cb_s1_ff <= `DDR_ZERO8;
			cb_s2_ff <= `DDR_ZERO8;
		end else begin
			rv_s1_ff <= mem_rvalid_i;
			rv_s2_ff <= rv_s1_ff;
			dq_s1_ff <= mem_dq_i;
			dq_s2_ff <= dq_s1_ff;
			cb_s1_ff <= memory_check_bits_i;
			cb_s2_ff <= cb_s1_ff;
		end
	end

	// ************************************************************
	// Arbitration and ECC check
	// ************************************************************

	state_t      st_ff, nxt_st;
	req_t        req_ff, nxt_req;
	port_t       last_ff, nxt_last;
	logic [3:0]  run_ff, nxt_run;
	logic        rr_ff, nxt_rr;
	mem_cmd_t    cmd_ff, nxt_cmd;
	logic [31:0] dq_ff, nxt_dq;
	logic        dqoe_ff, nxt_dqoe;
	logic [7:0]  cb_ff, nxt_cb;
	logic        cboe_ff, nxt_cboe;
	resp_t       resp_ff, nxt_resp;
	logic        sbe_ff, nxt_sbe;
	logic        mbe_ff, nxt_mbe;
	logic [31:0] eaddr_ff, nxt_eaddr;
	logic        evt_ff, nxt_evt;
	logic        capped, pv, av, bv;
	port_t       gnt;
	req_t        gnt_req;
	logic [6:0]  unit;
	logic        hit0, hit1;
	logic [31:0] off;
	logic [7:0]  rd_code;
	logic [6:0]  syn;
	logic        par_err, sbe_hit, mbe_hit;
	logic [31:0] fixed, merged;

	// Processor first, system buses round-robin, run capped at one burst
	always_comb begin
		capped = run_ff == `DDR_BURST_MAX;
		pv = proc_req_i.valid && !(capped && last_ff == PORT_PROC && (sysa_req_i.valid || sysb_req_i.valid));
		av = sysa_req_i.valid && !(capped && last_ff == PORT_SYSA && (proc_req_i.valid || sysb_req_i.valid));
		bv = sysb_req_i.valid && !(capped && last_ff == PORT_SYSB && (proc_req_i.valid || sysa_req_i.valid));
		if (pv) gnt = PORT_PROC;
		else if (av && bv) gnt = rr_ff ? PORT_SYSB : PORT_SYSA;
		else if (av) gnt = PORT_SYSA;
		else if (bv) gnt = PORT_SYSB;
		else gnt = PORT_NONE;
		unique case (gnt)
			PORT_PROC: gnt_req = proc_req_i;
			PORT_SYSA: gnt_req = sysa_req_i;
			PORT_SYSB: gnt_req = sysb_req_i;
			PORT_NONE: gnt_req = '0;
		endcase
		// Region starts at the aligned base; bank 1 follows bank 0
		unit = gnt_req.addr[`DDR_UNIT_MSB:`DDR_UNIT_LSB];
		hit0 = unit >= memory_base_setting_i && unit < bank0_boundary_setting_i;
		hit1 = unit >= bank0_boundary_setting_i && unit < bank1_boundary_setting_i;
		off = gnt_req.addr - {(hit1 ? bank0_boundary_setting_i : memory_base_setting_i), 25'h0};
		// Check on the read word, upper half of the code word held at zero
		rd_code = ecc_gen({`DDR_ZERO32, dq_s2_ff});
		syn = rd_code[6:0] ^ cb_s2_ff[6:0];
		par_err = ^{dq_s2_ff, cb_s2_ff};
		sbe_hit = ecc_en_i && par_err;
		mbe_hit = ecc_en_i && !par_err && syn != 7'h00;
		fixed = sbe_hit ? ecc_fix(dq_s2_ff, syn) : dq_s2_ff;
		for (int i = 0; i < 4; i++) begin
			merged[i*8 +: 8] = req_ff.be[i] ? req_ff.wdata[i*8 +: 8] : fixed[i*8 +: 8];
		end
	end

	// ************************************************************
	// Transfer sequencer
	// ************************************************************

	// Next values of the sequencer, memory pins, answer and error flags
	always_comb begin
		nxt_st = st_ff;
		nxt_req = req_ff;
		nxt_last = last_ff;
		nxt_run = run_ff;
		nxt_rr = rr_ff;
		nxt_cmd = cmd_ff;
		nxt_cmd.rd = 1'b0;
		nxt_cmd.wr = 1'b0;
		nxt_dq = dq_ff;
		nxt_dqoe = 1'b0;
		nxt_cb = cb_ff;
		nxt_cboe = 1'b0;
		nxt_resp = resp_ff;
		nxt_resp.valid = 1'b0;
		nxt_evt = 1'b0;
		nxt_eaddr = eaddr_ff;
		// Flags: a new error wins over a clear in the same cycle
		nxt_sbe = sbe_ff && !err_clr_i;
		nxt_mbe = mbe_ff && !err_clr_i;
		unique case (st_ff)
			S_IDLE: begin
				if (gnt != PORT_NONE) begin
					nxt_req = gnt_req;
					nxt_resp.port = gnt;
					nxt_resp.err = 1'b0;
					nxt_last = gnt;
					nxt_run = (gnt == last_ff && !capped) ? run_ff + 4'd1 : 4'd1;
					if (gnt != PORT_PROC) nxt_rr = gnt == PORT_SYSA;
					nxt_cmd = map_addr(off, dev_tech_i, dev_x16_i);
					nxt_cmd.cs_n = {~hit1, ~hit0};
					nxt_dq = gnt_req.wdata;
					nxt_cb = ecc_gen({`DDR_ZERO32, gnt_req.wdata});
					if (!hit0 && !hit1) begin
						nxt_resp.valid = 1'b1;
						nxt_resp.err = 1'b1;
						nxt_cmd.cs_n = `DDR_CS_IDLE;
						nxt_st = S_DONE;
					end else if (!gnt_req.wr || (ecc_en_i && gnt_req.be != `DDR_BE_ALL)) begin
						nxt_cmd.rd = 1'b1;
						nxt_st = S_RD;
					end else begin
						nxt_cmd.wr = 1'b1;
						nxt_dqoe = 1'b1;
						nxt_cboe = ecc_en_i;
						nxt_resp.valid = 1'b1;
						nxt_st = S_WR;
					end
				end
			end
			S_RD: begin
				nxt_st = S_WAIT;
			end
			S_WAIT: begin
				if (rv_s2_ff) begin
					if (sbe_hit || mbe_hit) begin
						nxt_sbe = nxt_sbe || sbe_hit;
						nxt_mbe = nxt_mbe || mbe_hit;
						nxt_eaddr = req_ff.addr;
						nxt_evt = 1'b1;
					end
					nxt_resp.rdata = fixed;
					nxt_resp.err = mbe_hit;
					nxt_resp.valid = 1'b1;
					// Reads end here: corrected words are not written back
					if (!req_ff.wr || mbe_hit) begin
						nxt_st = S_DONE;
					end else begin
						nxt_resp.valid = 1'b0;
						nxt_dq = merged;
						nxt_cb = ecc_gen({`DDR_ZERO32, merged});
						nxt_cmd.wr = 1'b1;
						nxt_dqoe = 1'b1;
						nxt_cboe = 1'b1;
						nxt_resp.valid = 1'b1;
						nxt_st = S_WR;
					end
				end
			end
			S_WR: begin
				nxt_cmd.cs_n = `DDR_CS_IDLE;
				nxt_st = S_IDLE;
			end
			S_DONE: begin
				nxt_cmd.cs_n = `DDR_CS_IDLE;
				nxt_st = S_IDLE;
			end
		endcase
	end

	// Commands go out straight from these flops: unbuffered devices only
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= S_IDLE;
			req_ff <= '0;
			last_ff <= PORT_NONE;
			run_ff <= 4'h0;
			rr_ff <= 1'b0;
			cmd_ff <= '{cs_n: `DDR_CS_IDLE, default: '0};
			dq_ff <= `DDR_ZERO32;
			dqoe_ff <= 1'b0;
			cb_ff <= `DDR_ZERO8;
			cboe_ff <= 1'b0;
			resp_ff <= '0;
			sbe_ff <= 1'b0;
			mbe_ff <= 1'b0;
			eaddr_ff <= `DDR_ZERO32;
			evt_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			req_ff <= nxt_req;
			last_ff <= nxt_last;
			run_ff <= nxt_run;
			rr_ff <= nxt_rr;
			cmd_ff <= nxt_cmd;
			dq_ff <= nxt_dq;
			dqoe_ff <= nxt_dqoe;
			cb_ff <= nxt_cb;
			cboe_ff <= nxt_cboe;
			resp_ff <= nxt_resp;
			sbe_ff <= nxt_sbe;
			mbe_ff <= nxt_mbe;
			eaddr_ff <= nxt_eaddr;
			evt_ff <= nxt_evt;
		end
	end

	// Outputs
	assign resp_o = resp_ff;
	assign mem_cmd_o = cmd_ff;
	assign mem_dq_o = dq_ff;
	assign mem_dq_oe_o = dqoe_ff;
	assign memory_check_bits_o = cb_ff;
	assign memory_check_bits_oe_o = cboe_ff;
	assign sbe_flag_o = sbe_ff;
	assign mbe_flag_o = mbe_ff;
	assign err_addr_o = eaddr_ff;
	assign err_event_o = evt_ff;

	// ************************************************************
	// Assertions
	// ************************************************************

	default clocking cb_chk @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_cs_one_bank: assert property (cmd_ff.cs_n != 2'b00)
		else $error("both chip selects active");
	chk_bank_decode: assert property ((cmd_ff.rd || cmd_ff.wr) |->
		cmd_ff.cs_n[0] == !(req_ff.addr[31:25] < bank0_boundary_setting_i))
		else $error("bank select does not match boundary");
	chk_write_code: assert property ((cmd_ff.wr && ecc_en_i) |->
		(cboe_ff && dqoe_ff && cb_ff == ecc_gen({32'h0000_0000, dq_ff})))
		else $error("check bits do not match written word");
	chk_rmw_read_first: assert property ((st_ff == S_IDLE && pv && gnt_req.wr && ecc_en_i
		&& gnt_req.be != 4'hf && (hit0 || hit1)) |=> cmd_ff.rd ##1 st_ff == S_WAIT)
		else $error("sub-word write did not start with a read");
	chk_proc_first: assert property ((st_ff == S_IDLE && pv) |=> req_ff == $past(proc_req_i))
		else $error("processor port not served first");
	chk_burst_cap: assert property (run_ff <= 4'd8)
		else $error("run longer than eight words");
	chk_no_scrub: assert property ((st_ff == S_WAIT && rv_s2_ff && !req_ff.wr) |=>
		!cmd_ff.wr ##1 !cmd_ff.wr)
		else $error("read caused a memory write");
	chk_mbe_flag: assert property ((st_ff == S_WAIT && rv_s2_ff && mbe_hit) |=>
		(mbe_ff && evt_ff && resp_ff.err && err_addr_o == $past(req_ff.addr)))
		else $error("multi-bit error not recorded");
	chk_fix_single: assert property ((st_ff == S_WAIT && rv_s2_ff && sbe_hit && !req_ff.wr) |=>
		(resp_ff.valid && $countones(ecc_gen({32'h0000_0000, resp_ff.rdata}) ^ $past(cb_s2_ff)) <= 1))
		else $error("single-bit error not corrected");

	cov_read: cover property (cmd_ff.rd ##[1:20] resp_ff.valid);
	cov_rmw: cover property (cmd_ff.rd ##[1:20] cmd_ff.wr);
	cov_single_fix: cover property (sbe_hit && rv_s2_ff && st_ff == S_WAIT);
	cov_cap: cover property (capped && st_ff == S_IDLE && gnt != last_ff && gnt != PORT_NONE);

endmodule
`default_nettype wire

//--- ddr_mem_model.sv
// Behavioural model of the external DDR memory devices with error injection
`timescale 1ns/10ps
`default_nettype none
module ddr_mem_model
	import ddr_ctrl_pkg::*;
(
	input  wire mem_cmd_t    mem_cmd_i,
	input  wire logic        core_clk_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic [7:0]  wcb_i,
	input  wire logic        slow_i,
	input  wire logic [1:0]  inject_i,
	output logic      [31:0] rdata_o,
	output logic      [7:0]  rcb_o,
	output logic             rvalid_o,
	output logic      [15:0] cmd_cnt_o
);
	logic [31:0] data_mem [logic [28:0]];
	logic [7:0]  code_mem [logic [28:0]];
	logic [28:0] key;
	logic [31:0] d;
	logic [7:0]  c;

	// Location key from select, leaf, row and column
	assign key = mem_cmd_i[30:2];

	initial begin
		rdata_o = 32'h5a5a_5a5a;
		rcb_o = 8'ha5;
		rvalid_o = 1'b0;
		cmd_cnt_o = 16'h0000;
	end

	// Stores all data and check bits; answers reads after a short or long delay
	always @(posedge core_clk_i) begin
		if (mem_cmd_i.wr === 1'b1) begin
			data_mem[key] = wdata_i;
			code_mem[key] = wcb_i;
			cmd_cnt_o = cmd_cnt_o + 16'h0001;
		end
		if (mem_cmd_i.rd === 1'b1) begin
			cmd_cnt_o = cmd_cnt_o + 16'h0001;
			d = data_mem.exists(key) ? data_mem[key] : 32'h0000_0000;
			c = code_mem.exists(key) ? code_mem[key] : 8'h00;
			if (inject_i == 2'h1) d[5] = ~d[5];
			if (inject_i == 2'h2) d[9:8] = ~d[9:8];
			repeat (slow_i ? 6 : 1) @(posedge core_clk_i);
			#1;
			rdata_o = d;
			rcb_o = c;
			rvalid_o = 1'b1;
			repeat (2) @(posedge core_clk_i);
			#1;
			// Released lines show the inverse so stale data cannot pass
			rvalid_o = 1'b0;
			rdata_o = ~d;
			rcb_o = ~c;
		end
	end
endmodule
`default_nettype wire

//--- ddr_sdram_ecc_controller_tb_top.sv
// Self-checking bench for the DDR SDRAM ECC controller core
`timescale 1ns/10ps
`default_nettype none
module ddr_sdram_ecc_controller_tb_top;
	import ddr_ctrl_pkg::*;
	localparam logic [31:0] w0  = 32'h0200_0100;
	localparam logic [31:0] off = 32'h1abc_def4;
	logic        core_clk_i, rst_n_i, ecc_en, err_clr, x16, slow, dq_oe, cb_oe, rvalid;
	logic        sbe, mbe, ev, ev_seen, dq_oe_seen, cb_oe_seen;
	req_t        proc_r, sysa_r, sysb_r;
	resp_t       resp, got;
	mem_cmd_t    cmd, seen;
	logic [31:0] dq_o, dq_in, dq_seen, err_addr;
	logic [7:0]  cb_o, cb_in;
	logic [6:0]  base, b0, b1;
	logic [1:0]  inject;
	logic [15:0] cnt, cnt0;
	tech_t       tech;
	int          miscompares, tests_run;

	always #2.5 core_clk_i = ~core_clk_i;

	ddr_sdram_ecc_controller u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.proc_req_i(proc_r), .sysa_req_i(sysa_r), .sysb_req_i(sysb_r), .resp_o(resp),
		.memory_base_setting_i(base), .bank0_boundary_setting_i(b0),
		.bank1_boundary_setting_i(b1), .dev_tech_i(tech), .dev_x16_i(x16),
		.ecc_en_i(ecc_en), .err_clr_i(err_clr), .mem_cmd_o(cmd), .mem_dq_o(dq_o),
		.mem_dq_oe_o(dq_oe), .mem_dq_i(dq_in), .memory_check_bits_o(cb_o),
		.memory_check_bits_oe_o(cb_oe), .memory_check_bits_i(cb_in),
		.mem_rvalid_i(rvalid), .sbe_flag_o(sbe), .mbe_flag_o(mbe),
		.err_addr_o(err_addr), .err_event_o(ev));

	ddr_mem_model u_mem (.mem_cmd_i(cmd), .core_clk_i(core_clk_i), .wdata_i(dq_o),
		.wcb_i(cb_o), .slow_i(slow), .inject_i(inject), .rdata_o(dq_in), .rcb_o(cb_in),
		.rvalid_o(rvalid), .cmd_cnt_o(cnt));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string name, input logic [31:0] got_v, input logic [31:0] exp_v);
		tests_run++;
		if (got_v !== exp_v) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp_v, got_v);
		end
	endtask

	task automatic results();
		if (miscompares == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic tick();
		@(posedge core_clk_i);
		#1;
	endtask

	task automatic set_req(input port_t p, input req_t r);
		case (p)
			PORT_PROC: proc_r = r;
			PORT_SYSA: sysa_r = r;
			default: sysb_r = r;
		endcase
	endtask

	// One request on a port, held until its tagged answer, then dropped
	task automatic access(input port_t p, input logic w, input logic [31:0] a,
			input logic [31:0] d, input logic [3:0] be);
		req_t r;
		int   n;
		r = '{1'b1, w, a, d, be};
		n = 0;
		set_req(p, r);
		do begin
			tick();
			n++;
		end while (!(resp.valid === 1'b1 && resp.port === p) && n < 300);
		if (n >= 300) begin
			miscompares++;
			results();
		end
		got = resp;
		seen = cmd;
		dq_seen = dq_o;
		dq_oe_seen = dq_oe;
		cb_oe_seen = cb_oe;
		ev_seen = ev;
		r.valid = 1'b0;
		set_req(p, r);
		tick();
	endtask

	// Processor streams writes while port A waits with a read
	task automatic burst();
		int k;
		int n;
		k = 0;
		proc_r = '{1'b1, 1'b1, w0 + 32'h0000_0008, 32'h0f0f_0f0f, 4'hf};
		sysa_r = '{1'b1, 1'b0, w0, 32'h0000_0000, 4'hf};
		for (n = 0; n < 400 && !(resp.valid === 1'b1 && resp.port === PORT_SYSA); n++) begin
			tick();
			if (resp.valid === 1'b1 && resp.port === PORT_PROC) begin
				k++;
				proc_r.valid = 1'b0;
			end else if (resp.valid !== 1'b1) begin
				proc_r.valid = 1'b1;
			end
		end
		if (n >= 400) begin
			miscompares++;
			results();
		end
		chk("burst_run", k, 32'h0000_0008);
		chk("burst_data", resp.rdata, 32'hcafe_ab34);
		proc_r.valid = 1'b0;
		sysa_r.valid = 1'b0;
		tick();
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		int colw;
		int roww;
		logic [31:0] word;
		core_clk_i = 1'b0;
		rst_n_i = 1'b0;
		{proc_r, sysa_r, sysb_r} = '0;
		{base, b0, b1} = {7'h01, 7'h11, 7'h21};
		{tech, x16, ecc_en, err_clr, slow, inject} = {TECH_128M, 6'h10};
		miscompares = 0;
		tests_run = 0;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk("cs_idle", 32'(cmd.cs_n), 32'h0000_0003);
		chk("idle_outs", 32'({resp.valid, dq_oe, cb_oe, sbe, mbe, ev}), 32'h0000_0000);
		rst_n_i = 1'b1;
		tick();
		// Leaf, row and column for every technology and width
		for (int t = 0; t < 4; t++) begin
			for (int x = 0; x < 2; x++) begin
				tech = tech_t'(t);
				x16 = x[0];
				access(PORT_PROC, 1'b0, 32'h0200_0000 + off, 32'h0000_0000, 4'hf);
				colw = 10 + int'(t >= 2) - x;
				roww = 12 + int'(t >= 1) + int'(t == 3);
				word = off >> 2;
				chk("leaf_low", 32'(seen.leaf_select_low), 32'(off[25 + t - x]));
				chk("leaf_high", 32'(seen.leaf_select_high), 32'(off[26 + t - x]));
				chk("col", 32'(seen.col), word & ((32'h0000_0001 << colw) - 1));
				chk("row", 32'(seen.row), (word >> colw) & ((32'h0000_0001 << roww) - 1));
				chk("bank0_sel", 32'(seen.cs_n), 32'h0000_0002);
			end
		end
		tech = TECH_1G;
		x16 = 1'b0;
		// Full word write, then read back on port A
		access(PORT_PROC, 1'b1, w0, 32'hcafe_1234, 4'hf);
		chk("wr_data", dq_seen, 32'hcafe_1234);
		chk("wr_code_oe", 32'(cb_oe_seen), 32'h0000_0001);
		access(PORT_SYSA, 1'b0, w0, 32'h0000_0000, 4'hf);
		chk("rd_data", got.rdata, 32'hcafe_1234);
		// Single-bit error with a slow memory answer
		slow = 1'b1;
		inject = 2'h1;
		access(PORT_SYSB, 1'b0, w0, 32'h0000_0000, 4'hf);
		chk("sbe_data", got.rdata, 32'hcafe_1234);
		chk("sbe_err", 32'({got.err, sbe, ev_seen}), 32'h0000_0003);
		chk("err_addr", err_addr, w0);
		err_clr = 1'b1;
		tick();
		err_clr = 1'b0;
		tick();
		chk("sbe_clear", 32'(sbe), 32'h0000_0000);
		// Double-bit error is reported, not corrected
		inject = 2'h2;
		access(PORT_SYSB, 1'b0, w0, 32'h0000_0000, 4'hf);
		chk("mbe_err", 32'({got.err, mbe}), 32'h0000_0003);
		inject = 2'h0;
		slow = 1'b0;
		err_clr = 1'b1;
		tick();
		err_clr = 1'b0;
		// Byte write merges into the stored word
		cnt0 = cnt;
		access(PORT_PROC, 1'b1, w0, 32'h0000_ab00, 4'h2);
		chk("rmw_cmds", 32'(cnt - cnt0), 32'h0000_0002);
		access(PORT_PROC, 1'b0, w0, 32'h0000_0000, 4'hf);
		chk("rmw_data", got.rdata, 32'hcafe_ab34);
		// Second bank
		access(PORT_PROC, 1'b1, 32'h2200_0040, 32'h1357_9bdf, 4'hf);
		chk("bank1_sel", 32'(seen.cs_n), 32'h0000_0001);
		access(PORT_SYSA, 1'b0, 32'h2200_0040, 32'h0000_0000, 4'hf);
		chk("bank1_data", got.rdata, 32'h1357_9bdf);
		// Addresses outside the region
		cnt0 = cnt;
		access(PORT_SYSA, 1'b0, 32'h0000_0010, 32'h0000_0000, 4'hf);
		chk("below_base", 32'(got.err), 32'h0000_0001);
		access(PORT_SYSA, 1'b1, 32'h4200_0000, 32'h0000_0000, 4'hf);
		chk("above_end", 32'(got.err), 32'h0000_0001);
		chk("no_access", 32'(cnt - cnt0), 32'h0000_0000);
		// Check bits stay undriven with ECC off
		ecc_en = 1'b0;
		access(PORT_SYSB, 1'b1, w0 + 32'h0000_0004, 32'h0000_0001, 4'hf);
		chk("noecc_oe", 32'({dq_oe_seen, cb_oe_seen}), 32'h0000_0002);
		ecc_en = 1'b1;
		burst();
		results();
	end
endmodule
`default_nettype wire
